// >>> hw/io_expander_pkg.sv
// Purpose: Shared constants for the I/O expander pin control logic
// Assumes: 20 MHz system clock, eight 8-bit ports
// Notes: Clock source divisors are derived from the system clock rate
package io_expander_pkg;
	localparam int          NPORT            = 8;
	localparam logic [7:0]  ADDR_INPUT       = 8'h00;
	localparam logic [7:0]  ADDR_OUTPUT      = 8'h08;
	localparam logic [7:0]  ADDR_INT_STATUS  = 8'h10;
	localparam logic [7:0]  ADDR_PORT_SELECT = 8'h18;
	localparam logic [7:0]  ADDR_INT_MASK    = 8'h19;
	localparam logic [7:0]  ADDR_SELECT_PWM  = 8'h1a;
	localparam logic [7:0]  ADDR_PWM_SELECT  = 8'h28;
	localparam logic [7:0]  ADDR_PWM_CONFIG  = 8'h29;
	localparam logic [7:0]  ADDR_PWM_PERIOD  = 8'h2a;
	localparam logic [7:0]  ADDR_PWM_WIDTH   = 8'h2b;
	localparam logic [7:0]  ADDR_PROG_DIV    = 8'h2c;
	localparam logic [7:0]  ADDR_FEATURE_EN  = 8'h2d;
	localparam logic [7:0]  RST_OUTPUT       = 8'hff;
	localparam logic [7:0]  RST_INT_MASK     = 8'hff;
	localparam logic [7:0]  RST_SELECT_PWM   = 8'h00;
	localparam logic [7:0]  RST_PERIOD       = 8'hff;
	localparam logic [7:0]  RST_WIDTH        = 8'h80;
	localparam logic [7:0]  RST_PROG_DIV     = 8'hff;
	localparam logic [7:0]  RST_FEATURE_EN   = 8'h00;
	localparam int          EN_EEPROM_BIT    = 0;
	localparam int          EN_WRITE_BLK_BIT = 1;
	localparam int          EN_READONLY_BIT  = 2;
	typedef enum logic [2:0] {
		SRC_32K  = 3'h0,
		SRC_24M  = 3'h1,
		SRC_1M5  = 3'h2,
		SRC_93K  = 3'h3,
		SRC_PROG = 3'h4,
		SRC_PREV = 3'h5
	} clk_src_e;
	localparam clk_src_e    RST_PWM_SRC      = SRC_32K;
	localparam int          CLK_HZ           = 20_000_000;
	localparam int          F_32K_HZ         = 32_000;
	localparam int          F_24M_HZ         = 24_000_000;
	localparam int          F_1M5_HZ         = 1_500_000;
	localparam int          F_93K_HZ         = 93_750;
	localparam int          DIV_W            = 10;
	function automatic int div_of(input int f);
		return (CLK_HZ / f < 1) ? 1 : CLK_HZ / f;
	endfunction : div_of
	localparam int          DIV_32K          = div_of(F_32K_HZ);
	localparam int          DIV_24M          = div_of(F_24M_HZ);
	localparam int          DIV_1M5          = div_of(F_1M5_HZ);
	localparam int          DIV_93K          = div_of(F_93K_HZ);
endpackage : io_expander_pkg

// >>> hw/pwm_channel.sv
// Purpose: One 8-bit PWM generator
// Assumes: tick is a one-cycle enable at the selected source rate
// Notes: Output is active while the count is below the width
`timescale 1ns/1ps
module pwm_channel (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       tick,
	input  wire logic [7:0] period,
	input  wire logic [7:0] width,
	output logic            pwm_out
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       out;
	} state_s;
	state_s st;
	state_s next_st;
	logic [8:0] inc;

	always_comb begin
		next_st = st;
		inc = {1'b0, st.cnt} + 9'h001;
		if (tick) begin
			if (inc >= {1'b0, period}) begin // [RULE15] [RULE19]
				next_st.cnt = 8'h00;
			end else begin
				next_st.cnt = inc[7:0];
			end
		end
		next_st.out = next_st.cnt < width; // [RULE16] [RULE19]
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pwm_out = st.out;
endmodule : pwm_channel

// >>> hw/addr_chain_decode.sv
// Purpose: Decodes the device address from the address pin chain
// Assumes: Pull strength of each pin is presented as a level input
// Notes: Captured once in the first cycle after reset release
`timescale 1ns/1ps
module addr_chain_decode (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       addr_bit_zero_pin,
	input  wire logic       addr_bit_zero_strong,
	input  wire logic [5:0] extended_addr_pins,
	input  wire logic [5:0] extended_addr_strong,
	output logic [6:0]      dev_addr,
	output logic [5:0]      addr_pin_used,
	output logic            addr_valid
);
	typedef struct packed {
		logic       captured;
		logic [6:0] addr;
		logic [5:0] used;
	} state_s;
	state_s st;
	state_s next_st;
	logic   reach;

	always_comb begin
		next_st = st;
		reach = 1'b0;
		if (!st.captured) begin // [RULE20]
			next_st.captured = 1'b1;
			next_st.addr[0] = addr_bit_zero_pin; // [RULE1]
			reach = !addr_bit_zero_strong; // [RULE1] [RULE2]
			for (int k = 0; k < 6; k++) begin
				next_st.used[k] = reach; // [RULE3]
				next_st.addr[k + 1] = reach & extended_addr_pins[k];
				reach = reach & !extended_addr_strong[k]; // [RULE2] [RULE3]
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dev_addr      = st.addr;
	assign addr_pin_used = st.used;
	assign addr_valid    = st.captured;
endmodule : addr_chain_decode

// >>> hw/io_expander_pin_control.sv
// Purpose: Pin control of an I/O expander: ports, interrupts, PWMs, write block
// Assumes: Register strobes come from the serial slave; pins synchronous to mclk
// Notes: Full reset from sys_rst or the external reset pin
// Functional notes
// RULE1 - First address pin always used; strong ends chain
// RULE2 - Weak pull extends address chain to next pin
// RULE3 - Chain ends at strong pin; later pins GPIO
// RULE4 - Unmasked GPIO change raises interrupt output
// RULE5 - Unmasked slow-source PWM change raises interrupt
// RULE6 - Reading status register drops its interrupt
// RULE7 - Write-block pin sampled at each write request
// RULE8 - Pin ignored if EEPROM disabled or read-only
// RULE9 - Blocked pin refuses every EEPROM command
// RULE10 - Enable register bit 1 enables write block
// RULE11 - External reset pin high fully resets device
// RULE12 - Four/eight/sixteen PWMs; select bit makes pin PWM
// RULE13 - Six selectable clock sources per PWM
// RULE14 - PWM source defaults to 32 kHz
// RULE15 - Output period equals period times clock period
// RULE16 - Width over period gives duty; software bounds width
// RULE17 - Pin state: output bit AND PWM when selected
// RULE18 - Status bit on change; cleared by its read
// RULE19 - Eight-bit counter wraps at period, compare width
// RULE20 - Address configuration latched once after reset
`timescale 1ns/1ps
module io_expander_pin_control #(
	parameter int NPWM = 16
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        external_reset_pin,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	output logic             reg_rvalid,
	input  wire logic [63:0] pin_in,
	output logic [63:0]      pin_drive,
	output logic             int_out,
	input  wire logic        eeprom_write_block_pin,
	input  wire logic        ee_op_req,
	output logic             ee_op_grant,
	output logic             ee_op_refuse,
	input  wire logic        addr_bit_zero_pin,
	input  wire logic        addr_bit_zero_strong,
	input  wire logic [5:0]  extended_addr_pins,
	input  wire logic [5:0]  extended_addr_strong,
	output logic [6:0]       dev_addr,
	output logic [5:0]       addr_pin_used,
	output logic             addr_valid
);
	localparam int NPORT = io_expander_pkg::NPORT;
	localparam int NPIN  = NPORT * 8;
	localparam int CH_W  = (NPWM > 1) ? $clog2(NPWM) : 1;
	localparam int DW    = io_expander_pkg::DIV_W;

	typedef struct packed {
		logic [NPORT-1:0][7:0]                 out_port;
		logic [NPORT-1:0][7:0]                 int_status;
		logic [NPORT-1:0][7:0]                 int_mask;
		logic [NPORT-1:0][7:0]                 sel_pwm;
		logic [NPORT-1:0]                      int_pend;
		logic [2:0]                            port_sel;
		logic [CH_W-1:0]                       pwm_sel;
		logic [NPWM-1:0][2:0]                  pwm_src;
		logic [NPWM-1:0][7:0]                  pwm_period;
		logic [NPWM-1:0][7:0]                  pwm_width;
		logic [7:0]                            prog_div;
		logic [7:0]                            feature_enable;
		logic [NPIN-1:0]                       pin_last;
		logic [NPWM-1:0]                       pwm_last;
		logic [NPIN-1:0]                       drive;
		logic [3:0][DW-1:0]                    div_cnt;
		logic [7:0]                            prog_cnt;
		logic [3:0]                            ticks;
		logic                                  t_prog;
		logic [7:0]                            rdata;
		logic                                  rvalid;
		logic                                  grant;
		logic                                  refuse;
	} state_s;

	state_s          st;
	state_s          next_st;
	logic            rst;
	logic [NPWM-1:0] pwm_out;
	logic [NPWM-1:0] pwm_tick;
	logic [NPIN-1:0] pwm_chg;
	logic [NPIN-1:0] slow_chg;
	logic [NPIN-1:0] status_set;
	logic [NPIN-1:0] int_set;
	logic            blocked;
	logic [2:0]      bank_idx;

	// Tick counter step; returns tick flag above the next count
	function automatic logic [DW:0] div_step(input logic [DW-1:0] cnt,
			input logic [DW-1:0] top, input logic en);
		if (!en) begin
			return {1'b0, cnt};
		end else if (cnt >= top) begin
			return {1'b1, {DW{1'b0}}};
		end else begin
			return {1'b0, DW'(cnt + 1'b1)};
		end
	endfunction : div_step

	// PWM channel that serves a pin
	function automatic int chan_of(input int pin);
		return pin % NPWM;
	endfunction : chan_of

	assign rst = sys_rst | external_reset_pin; // [RULE11]

	addr_chain_decode u_addr (
		.mclk                 (mclk),
		.sys_rst              (rst),
		.addr_bit_zero_pin    (addr_bit_zero_pin),
		.addr_bit_zero_strong (addr_bit_zero_strong),
		.extended_addr_pins   (extended_addr_pins),
		.extended_addr_strong (extended_addr_strong),
		.dev_addr             (dev_addr),
		.addr_pin_used        (addr_pin_used),
		.addr_valid           (addr_valid)
	);

	// Clock source selection per channel
	always_comb begin
		for (int c = 0; c < NPWM; c++) begin
			case (io_expander_pkg::clk_src_e'(st.pwm_src[c])) // [RULE13]
				io_expander_pkg::SRC_32K:  pwm_tick[c] = st.ticks[0];
				io_expander_pkg::SRC_24M:  pwm_tick[c] = st.ticks[1];
				io_expander_pkg::SRC_1M5:  pwm_tick[c] = st.ticks[2];
				io_expander_pkg::SRC_93K:  pwm_tick[c] = st.ticks[3];
				io_expander_pkg::SRC_PROG: pwm_tick[c] = st.t_prog;
				io_expander_pkg::SRC_PREV: begin
					pwm_tick[c] = pwm_out[(c + NPWM - 1) % NPWM] &
						!st.pwm_last[(c + NPWM - 1) % NPWM];
				end
				default:                   pwm_tick[c] = st.ticks[0];
			endcase
		end
	end

	for (genvar g = 0; g < NPWM; g++) begin : g_pwm // [RULE12]
		pwm_channel u_pwm (
			.mclk    (mclk),
			.sys_rst (rst),
			.tick    (pwm_tick[g]),
			.period  (st.pwm_period[g]),
			.width   (st.pwm_width[g]),
			.pwm_out (pwm_out[g])
		);
	end

	// Change events per pin
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			pwm_chg[i] = st.sel_pwm[i / 8][i % 8] &
				(pwm_out[chan_of(i)] ^ st.pwm_last[chan_of(i)]);
			slow_chg[i] = pwm_chg[i] &
				(st.pwm_src[chan_of(i)] == io_expander_pkg::SRC_PROG); // [RULE5]
		end
		status_set = (pin_in ^ st.pin_last) | pwm_chg; // [RULE18]
		int_set = ((pin_in ^ st.pin_last) | slow_chg) & ~st.int_mask; // [RULE4] [RULE5]
	end

	assign blocked = st.feature_enable[io_expander_pkg::EN_WRITE_BLK_BIT] & // [RULE10]
		st.feature_enable[io_expander_pkg::EN_EEPROM_BIT] &
		!st.feature_enable[io_expander_pkg::EN_READONLY_BIT] & // [RULE8]
		eeprom_write_block_pin; // [RULE7]
	assign bank_idx = reg_addr[2:0];

	always_comb begin
		logic [DW:0] step;
		logic [7:0]  pdiv;
		next_st = st;
		step = '0;
		pdiv = 8'h00;
		// Source dividers
		step = div_step(st.div_cnt[0], DW'(io_expander_pkg::DIV_32K - 1), 1'b1);
		next_st.div_cnt[0] = step[DW-1:0];
		next_st.ticks[0] = step[DW];
		step = div_step(st.div_cnt[1], DW'(io_expander_pkg::DIV_24M - 1), 1'b1);
		next_st.div_cnt[1] = step[DW-1:0];
		next_st.ticks[1] = step[DW];
		step = div_step(st.div_cnt[2], DW'(io_expander_pkg::DIV_1M5 - 1), 1'b1);
		next_st.div_cnt[2] = step[DW-1:0];
		next_st.ticks[2] = step[DW];
		step = div_step(st.div_cnt[3], DW'(io_expander_pkg::DIV_93K - 1), 1'b1);
		next_st.div_cnt[3] = step[DW-1:0];
		next_st.ticks[3] = step[DW];
		pdiv = (st.prog_div == 8'h00) ? 8'h00 : st.prog_div - 8'h01;
		step = div_step({{(DW-8){1'b0}}, st.prog_cnt}, {{(DW-8){1'b0}}, pdiv},
			st.ticks[3]);
		next_st.prog_cnt = step[7:0];
		next_st.t_prog = step[DW];
		// Pin history and drive
		next_st.pin_last = pin_in;
		next_st.pwm_last = pwm_out;
		for (int i = 0; i < NPIN; i++) begin
			next_st.drive[i] = st.out_port[i / 8][i % 8] &
				(!st.sel_pwm[i / 8][i % 8] | pwm_out[chan_of(i)]); // [RULE17]
		end
		// EEPROM command gating
		next_st.grant = ee_op_req & !blocked; // [RULE7]
		next_st.refuse = ee_op_req & blocked; // [RULE9]
		// Register read
		next_st.rvalid = reg_rd;
		next_st.rdata = st.rdata;
		if (reg_rd) begin
			next_st.rdata = 8'h00;
			case (reg_addr[7:3])
				5'h00: next_st.rdata = pin_in[bank_idx * 8 +: 8];
				5'h01: next_st.rdata = st.out_port[bank_idx];
				5'h02: begin
					next_st.rdata = st.int_status[bank_idx];
					next_st.int_status[bank_idx] = 8'h00; // [RULE18]
					next_st.int_pend[bank_idx] = 1'b0; // [RULE6]
				end
				default: begin
					case (reg_addr)
						io_expander_pkg::ADDR_PORT_SELECT: next_st.rdata = {5'h00, st.port_sel};
						io_expander_pkg::ADDR_INT_MASK:    next_st.rdata = st.int_mask[st.port_sel];
						io_expander_pkg::ADDR_SELECT_PWM:  next_st.rdata = st.sel_pwm[st.port_sel];
						io_expander_pkg::ADDR_PWM_SELECT:  next_st.rdata = 8'(st.pwm_sel);
						io_expander_pkg::ADDR_PWM_CONFIG:  next_st.rdata = {5'h00, st.pwm_src[st.pwm_sel]};
						io_expander_pkg::ADDR_PWM_PERIOD:  next_st.rdata = st.pwm_period[st.pwm_sel];
						io_expander_pkg::ADDR_PWM_WIDTH:   next_st.rdata = st.pwm_width[st.pwm_sel];
						io_expander_pkg::ADDR_PROG_DIV:    next_st.rdata = st.prog_div;
						io_expander_pkg::ADDR_FEATURE_EN:  next_st.rdata = st.feature_enable;
						default:                           next_st.rdata = 8'h00;
					endcase
				end
			endcase
		end
		// Register write
		if (reg_wr) begin
			if (reg_addr[7:3] == 5'h01) begin
				next_st.out_port[bank_idx] = reg_wdata;
			end
			case (reg_addr)
				io_expander_pkg::ADDR_PORT_SELECT: next_st.port_sel = reg_wdata[2:0];
				io_expander_pkg::ADDR_INT_MASK:    next_st.int_mask[st.port_sel] = reg_wdata;
				io_expander_pkg::ADDR_SELECT_PWM:  next_st.sel_pwm[st.port_sel] = reg_wdata; // [RULE12]
				io_expander_pkg::ADDR_PWM_SELECT:  next_st.pwm_sel = reg_wdata[CH_W-1:0];
				io_expander_pkg::ADDR_PWM_CONFIG:  next_st.pwm_src[st.pwm_sel] = reg_wdata[2:0]; // [RULE13]
				io_expander_pkg::ADDR_PWM_PERIOD:  next_st.pwm_period[st.pwm_sel] = reg_wdata; // [RULE15]
				io_expander_pkg::ADDR_PWM_WIDTH:   next_st.pwm_width[st.pwm_sel] = reg_wdata; // [RULE16]
				io_expander_pkg::ADDR_PROG_DIV:    next_st.prog_div = reg_wdata;
				io_expander_pkg::ADDR_FEATURE_EN:  next_st.feature_enable = reg_wdata; // [RULE10]
				default: begin
				end
			endcase
		end
		// Events win over a clear in the same cycle
		for (int p = 0; p < NPORT; p++) begin
			next_st.int_status[p] = next_st.int_status[p] | status_set[p * 8 +: 8]; // [RULE18]
			next_st.int_pend[p] = next_st.int_pend[p] | (|int_set[p * 8 +: 8]); // [RULE4] [RULE5]
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin // [RULE11]
			st <= '0;
			for (int p = 0; p < NPORT; p++) begin
				st.out_port[p] <= io_expander_pkg::RST_OUTPUT;
				st.int_mask[p] <= io_expander_pkg::RST_INT_MASK;
				st.sel_pwm[p]  <= io_expander_pkg::RST_SELECT_PWM;
			end
			for (int c = 0; c < NPWM; c++) begin
				st.pwm_src[c]    <= io_expander_pkg::RST_PWM_SRC; // [RULE14]
				st.pwm_period[c] <= io_expander_pkg::RST_PERIOD;
				st.pwm_width[c]  <= io_expander_pkg::RST_WIDTH;
			end
			st.prog_div       <= io_expander_pkg::RST_PROG_DIV;
			st.feature_enable <= io_expander_pkg::RST_FEATURE_EN;
			st.pin_last       <= pin_in; // [RULE18]
		end else begin
			st <= next_st;
		end
	end

	assign int_out      = |st.int_pend; // [RULE6]
	assign pin_drive    = st.drive;
	assign reg_rdata    = st.rdata;
	assign reg_rvalid   = st.rvalid;
	assign ee_op_grant  = st.grant;
	assign ee_op_refuse = st.refuse;
endmodule : io_expander_pin_control

// >>> tb/io_expander_assertions.sv
// Purpose: Port checker for io_expander_pin_control
// Assumes: One mclk domain; either reset input clears the device
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module io_expander_checker (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        external_reset_pin,
	input  wire logic        reg_rd,
	input  wire logic        reg_rvalid,
	input  wire logic [63:0] pin_drive,
	input  wire logic        int_out,
	input  wire logic        eeprom_write_block_pin,
	input  wire logic        ee_op_req,
	input  wire logic        ee_op_grant,
	input  wire logic        ee_op_refuse,
	input  wire logic [6:0]  dev_addr,
	input  wire logic [5:0]  addr_pin_used,
	input  wire logic        addr_valid
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst || external_reset_pin);
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe not answered");
	a_gate_answer: assert property (ee_op_req |=> (ee_op_grant != ee_op_refuse))
		else $error("eeprom request not answered once");
	a_refuse_cause: assert property (ee_op_refuse |-> $past(ee_op_req) && $past(eeprom_write_block_pin))
		else $error("refusal without high block pin");
	a_low_pin_grant: assert property (ee_op_req && !eeprom_write_block_pin |=> ee_op_grant)
		else $error("low block pin not granted");
	a_ext_reset_clear: assert property (disable iff (sys_rst)
		external_reset_pin |=> pin_drive == 64'h0 && !int_out && !addr_valid)
		else $error("external reset did not clear outputs");
	a_addr_stable: assert property (addr_valid && $past(addr_valid) |->
		$stable(dev_addr) && $stable(addr_pin_used))
		else $error("address changed while latched");
	a_chain_shape: assert property (((addr_pin_used + 6'h01) & addr_pin_used) == 6'h00)
		else $error("address pins not a contiguous chain");
	a_gpio_bits_zero: assert property ((dev_addr[6:1] & ~addr_pin_used) == 6'h00)
		else $error("gpio pin leaked into address");
	a_valid_after_rst: assert property ($fell(sys_rst) |-> ##[0:2] addr_valid)
		else $error("address not captured after reset");
endmodule : io_expander_checker
bind io_expander_pin_control io_expander_checker chk_u (.mclk, .sys_rst, .external_reset_pin,
	.reg_rd, .reg_rvalid, .pin_drive, .int_out, .eeprom_write_block_pin, .ee_op_req,
	.ee_op_grant, .ee_op_refuse, .dev_addr, .addr_pin_used, .addr_valid);

// >>> tb/host_reg_master.sv
// Purpose: Host side model issuing register byte accesses
// Assumes: Strobes are one-cycle pulses taken at the next rising edge
// Notes: Read answer awaited under a bounded count
`timescale 1ns/1ps
module host_reg_master (
	input  wire logic       mclk,
	input  wire logic       reg_rvalid,
	input  wire logic [7:0] reg_rdata,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		ok = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata;
			end else begin
				@(posedge mclk);
			end
		end
	endtask : rd
endmodule : host_reg_master

// >>> tb/io_expander_pin_control_tb_top.sv
// Purpose: Self-checking bench for io_expander_pin_control
// Assumes: 20 MHz mclk, host model drives the register strobes
// Notes: Address chain is re-latched through the external reset pin
`timescale 1ns/1ps
module io_expander_pin_control_tb_top;
	logic        mclk, sys_rst, external_reset_pin, reg_wr, reg_rd, reg_rvalid, int_out;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [63:0] pin_in, pin_drive;
	logic        eeprom_write_block_pin, ee_op_req, ee_op_grant, ee_op_refuse;
	logic        addr_bit_zero_pin, addr_bit_zero_strong, addr_valid;
	logic [5:0]  extended_addr_pins, extended_addr_strong, addr_pin_used, exp_used;
	logic [6:0]  dev_addr;
	int          error_cnt, n_checks, hi;
	logic [6:0]  cfg [4] = '{7'h7f, 7'h04, 7'h01, 7'h20};
	logic [15:0] rst_tab [11] = '{16'h08ff, 16'h0fff, 16'h19ff, 16'h1a00, 16'h2aff,
		16'h2b80, 16'h2cff, 16'h2d00, 16'h2900, 16'h1000, 16'h3000};
	logic [9:0]  ee_tab [7] = '{10'h100, 10'h101, 10'h102, 10'h303, 10'h107, 10'h003, 10'h106};
	io_expander_pin_control dut_u (.mclk, .sys_rst, .external_reset_pin, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .pin_in, .pin_drive, .int_out,
		.eeprom_write_block_pin, .ee_op_req, .ee_op_grant, .ee_op_refuse, .addr_bit_zero_pin,
		.addr_bit_zero_strong, .extended_addr_pins, .extended_addr_strong, .dev_addr,
		.addr_pin_used, .addr_valid);
	host_reg_master host_u (.mclk, .reg_rvalid, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd);
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		host_u.rd(a, d, v);
		if (v !== 1'b1) begin
			$display("wrong value reg_rvalid expected 1 seen %b", v);
			error_cnt++;
			final_report();
		end
		chk("reg_rdata", 64'(e), 64'(d));
	endtask : rchk
	task automatic count_hi(input int n);
		hi = 0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (pin_drive[1] === 1'b1) hi++;
		end
	endtask : count_hi
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		error_cnt = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		external_reset_pin = 1'b0;
		pin_in = 64'h0;
		eeprom_write_block_pin = 1'b0;
		ee_op_req = 1'b0;
		addr_bit_zero_pin = 1'b1;
		addr_bit_zero_strong = 1'b1;
		extended_addr_pins = 6'h2a;
		extended_addr_strong = 6'h3f;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		// Address chain per pull strength, re-latched by the external reset
		for (int i = 0; i < 4; i++) begin
			addr_bit_zero_strong <= cfg[i][6];
			extended_addr_strong <= cfg[i][5:0];
			extended_addr_pins <= 6'h2a;
			if (i > 0) begin
				host_u.wr(8'h2d, 8'h07);
				host_u.wr(8'h08, 8'h00);
				@(posedge mclk);
				external_reset_pin <= 1'b1;
				@(posedge mclk);
				external_reset_pin <= 1'b0;
			end
			repeat (3) @(posedge mclk);
			extended_addr_pins <= 6'h15;
			exp_used = 6'h00;
			for (int k = 0; k < 6 && !cfg[i][6]; k++) begin
				exp_used[k] = 1'b1;
				if (cfg[i][k]) break;
			end
			#1;
			chk("addr_pin_used", 64'(exp_used), 64'(addr_pin_used));
			chk("dev_addr", 64'({6'h2a & exp_used, 1'b1}), 64'(dev_addr));
		end
		foreach (rst_tab[i]) rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
		for (int k = 0; k < 6; k++) begin
			host_u.wr(8'h29, 8'(k));
			rchk(8'h29, 8'(k));
		end
		// Input change interrupts on port 0, bit 2 stays masked
		host_u.wr(8'h19, 8'hfc);
		@(posedge mclk);
		pin_in <= 64'h5;
		repeat (3) @(posedge mclk);
		#1;
		chk("int_out", 64'h1, 64'(int_out));
		rchk(8'h10, 8'h05);
		repeat (2) @(posedge mclk);
		#1;
		chk("int_out", 64'h0, 64'(int_out));
		rchk(8'h10, 8'h00);
		@(posedge mclk);
		pin_in <= 64'h1;
		repeat (3) @(posedge mclk);
		#1;
		chk("int_out", 64'h0, 64'(int_out));
		rchk(8'h10, 8'h04);
		// Output bits and fast PWM on pin 1
		host_u.wr(8'h08, 8'h0f);
		repeat (3) @(posedge mclk);
		#1;
		chk("pin_drive", 64'hffff_ffff_ffff_ff0f, pin_drive);
		host_u.wr(8'h1a, 8'h02);
		host_u.wr(8'h28, 8'h01);
		host_u.wr(8'h29, 8'h01);
		host_u.wr(8'h2a, 8'h04);
		host_u.wr(8'h2b, 8'h01);
		repeat (10) @(posedge mclk);
		count_hi(40);
		chk("pwm high cycles", 64'd10, 64'(hi));
		chk("int_out", 64'h0, 64'(int_out));
		rchk(8'h10, 8'h02);
		host_u.wr(8'h08, 8'h0d);
		repeat (3) @(posedge mclk);
		count_hi(8);
		chk("pwm gated low", 64'd0, 64'(hi));
		host_u.wr(8'h08, 8'h0f);
		// Medium source drives the same channel at half duty
		host_u.wr(8'h29, 8'h02);
		host_u.wr(8'h2a, 8'h02);
		repeat (30) @(posedge mclk);
		count_hi(4 * io_expander_pkg::DIV_1M5);
		chk("pwm 1.5M high cycles", 64'(2 * io_expander_pkg::DIV_1M5), 64'(hi));
		// Slow programmable source raises the interrupt
		host_u.wr(8'h2c, 8'h01);
		host_u.wr(8'h2a, 8'h02);
		host_u.wr(8'h29, 8'h04);
		rchk(8'h2a, 8'h02);
		hi = 0;
		for (int i = 0; i < 700 && hi == 0; i++) begin
			@(posedge mclk);
			#1;
			if (int_out === 1'b1) hi = 1;
		end
		chk("slow pwm int_out", 64'd1, 64'(hi));
		if (hi == 0) final_report();
		// Write block gating across enable settings
		foreach (ee_tab[i]) begin
			host_u.wr(8'h2d, ee_tab[i][7:0]);
			@(posedge mclk);
			eeprom_write_block_pin <= ee_tab[i][8];
			ee_op_req <= 1'b1;
			@(posedge mclk);
			ee_op_req <= 1'b0;
			#1;
			chk("ee_op_refuse", 64'(ee_tab[i][9]), 64'(ee_op_refuse));
			chk("ee_op_grant", 64'(!ee_tab[i][9]), 64'(ee_op_grant));
			rchk(8'h2d, ee_tab[i][7:0]);
		end
		final_report();
	end
endmodule : io_expander_pin_control_tb_top
